//--- common/pod_pkg.sv
// --------------------------------------------------------------------------
// Shared constants and carriers of the peak and overlevel detector
// --------------------------------------------------------------------------
package pod_pkg;

    // Sample width of the filtered datapath, number of phases and register address width.
    localparam int POD_DATA_W = 24;
    localparam int POD_NPH = 3;
    localparam int POD_ADDR_W = 8;

    // Register byte addresses.
    localparam logic [7:0] POD_ADDR_VPK = 8'h00;
    localparam logic [7:0] POD_ADDR_IPK = 8'h04;
    localparam logic [7:0] POD_ADDR_OVL = 8'h08;
    localparam logic [7:0] POD_ADDR_OIL = 8'h0c;
    localparam logic [7:0] POD_ADDR_CYC = 8'h10;
    localparam logic [7:0] POD_ADDR_MODE = 8'h14;
    localparam logic [7:0] POD_ADDR_ST1 = 8'h18;
    localparam logic [7:0] POD_ADDR_MSK1 = 8'h1c;
    localparam logic [7:0] POD_ADDR_PHST = 8'h20;

    // Field positions.
    localparam int POD_SEL_LSB = 2;
    localparam int POD_PKPH_LSB = 24;
    localparam int POD_ST_OI = 17;
    localparam int POD_ST_OV = 18;
    localparam int POD_ST_PKI = 23;
    localparam int POD_ST_PKV = 24;
    localparam int POD_PH_OI_LSB = 3;
    localparam int POD_PH_OV_LSB = 9;

    // Largest magnitude the filter can produce, the reset values, and the largest and most negative 24-bit codes.
    localparam logic [23:0] POD_FULL_SCALE = 24'h5a7540;
    localparam logic [23:0] POD_LVL_RST = 24'h5a7540;
    localparam logic [7:0] POD_CYC_RST = 8'h10;
    localparam logic [23:0] POD_ABS_MAX = 24'h7fffff;
    localparam logic [23:0] POD_MOST_NEG = 24'h800000;

    // One valid set of per-phase signed samples.
    typedef struct packed {
        logic [POD_NPH-1:0][POD_DATA_W-1:0] volt;
        logic [POD_NPH-1:0][POD_DATA_W-1:0] curr;
    } pod_samples_t;

    // One register access request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [POD_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } pod_regreq_t;

endpackage

//--- logic/pod_detector.sv
// Contract
// - Track largest absolute sample per channel period.
// - Period counts half cycles via zero crossings.
// - Mode bits 4:2 select phases A, B, C.
// - All selected phases advance one period counter.
// - Peak result marks source phase, one-hot.
// - Peak result updates only at period end.
// - Period end sets current-peak flag bit 23.
// - Period end sets voltage-peak flag bit 24.
// - Enabled set flag drives interrupt low.
// - Write one clears flag; interrupt then releases.
// - Period-count write with selection resets counter.
// - Compare absolute samples against 24-bit levels.
// - Overvoltage sets flag 18 and phase bits.
// - Clearing flag 18 clears overvoltage phase bits.
// - Overcurrent sets flag 17 and phase bits.
// - Clearing flag 17 clears overcurrent phase bits.
// - Full-scale level never detects anything.
// - Zero level detects on every valid sample.
// - Levels read as words, upper byte zero.
`timescale 1ns/1ps

module pod_detector
    import pod_pkg::*;
#(
    parameter int CYC_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pod_samples_t samples,
    input wire logic sampleValid,
    input wire logic [POD_NPH-1:0] zeroCross,
    input wire pod_regreq_t regReq,
    output logic [31:0] regRdData,
    output logic interruptOut_n
);

    // ----------------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------------

    // One byte at most on the port, yet wide enough for the reset of 16.
    if (CYC_W < 5 || CYC_W > 8) begin : gBadCycW
        $error("CYC_W must lie between 5 and 8");
    end

    // ----------------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------------

    logic [23:0] ovLevel_ff;              // Overvoltage level.
    logic [23:0] oiLevel_ff;              // Overcurrent level.
    logic [CYC_W-1:0] peakCycles_ff;      // Half cycles per period.
    logic [POD_NPH-1:0] phaseSel_ff;      // Peak phase selection.
    logic [3:0] irqMask_ff;               // Mask of the four flags.
    logic [CYC_W-1:0] zcCount_ff;         // Zero crossings so far.
    logic [23:0] runMaxV_ff;              // Running voltage maximum.
    logic [23:0] runMaxI_ff;              // Running current maximum.
    logic [POD_NPH-1:0] runPhV_ff;        // Phase of voltage maximum.
    logic [POD_NPH-1:0] runPhI_ff;        // Phase of current maximum.
    logic [23:0] peakV_ff;                // Reported voltage peak.
    logic [23:0] peakI_ff;                // Reported current peak.
    logic [POD_NPH-1:0] peakPhV_ff;       // Reported voltage phase.
    logic [POD_NPH-1:0] peakPhI_ff;       // Reported current phase.
    logic ovFlag_ff;                      // Sticky overvoltage flag.
    logic oiFlag_ff;                      // Sticky overcurrent flag.
    logic pkiFlag_ff;                     // Sticky current-peak flag.
    logic pkvFlag_ff;                     // Sticky voltage-peak flag.
    logic [POD_NPH-1:0] overvoltage_phase_bits_ff;       // Overvoltage phase bits.
    logic [POD_NPH-1:0] overcurrent_phase_bits_ff;       // Overcurrent phase bits.

    // ----------------------------------------------------------------------
    // Decode and per-phase magnitudes
    // ----------------------------------------------------------------------

    logic wrCyc, wrMode, wrSt1, wrMsk, wrOvl, wrOil;
    logic [POD_NPH-1:0][23:0] absV;
    logic [POD_NPH-1:0][23:0] absI;
    logic [POD_NPH-1:0] vOver;
    logic [POD_NPH-1:0] iOver;

    assign wrCyc = regReq.wr && regReq.addr == POD_ADDR_CYC;
    assign wrMode = regReq.wr && regReq.addr == POD_ADDR_MODE;
    assign wrSt1 = regReq.wr && regReq.addr == POD_ADDR_ST1;
    assign wrMsk = regReq.wr && regReq.addr == POD_ADDR_MSK1;
    assign wrOvl = regReq.wr && regReq.addr == POD_ADDR_OVL;
    assign wrOil = regReq.wr && regReq.addr == POD_ADDR_OIL;

    // Magnitude of a signed sample; the most negative code saturates
    // because its true magnitude does not fit in the same width.
    function automatic logic [23:0] absOf(input logic [23:0] s);
        if (s == POD_MOST_NEG) begin
            return POD_ABS_MAX;
        end
        return s[23] ? 24'(-s) : s;
    endfunction

    // Each phase gets its magnitude and its instantaneous comparisons.
    // A zero level detects even a zero sample, which a strict greater
    // than would miss; full scale is never exceeded by any sample.
    for (genvar p = 0; p < POD_NPH; p++) begin : gPhase
        assign absV[p] = absOf(samples.volt[p]);
        assign absI[p] = absOf(samples.curr[p]);
        assign vOver[p] = sampleValid &&
            (absV[p] > ovLevel_ff || ovLevel_ff == 24'h000000);
        assign iOver[p] = sampleValid &&
            (absI[p] > oiLevel_ff || oiLevel_ff == 24'h000000);
    end

    // ----------------------------------------------------------------------
    // Period timing
    // ----------------------------------------------------------------------

    logic [1:0] zcHits;
    logic [CYC_W:0] zcSum;
    logic periodEnd;
    logic periodRestart;

    // Crossings of every selected phase count toward the same period,
    // so selecting more phases shortens the period in proportion.
    assign zcHits = {1'b0, zeroCross[0] & phaseSel_ff[0]}
        + {1'b0, zeroCross[1] & phaseSel_ff[1]}
        + {1'b0, zeroCross[2] & phaseSel_ff[2]};
    assign zcSum = {1'b0, zcCount_ff} + (CYC_W+1)'(zcHits);
    assign periodEnd = zcHits != 2'b00
        && zcSum >= {1'b0, peakCycles_ff};
    // Rewriting the period count with phases selected starts afresh so
    // that the first result really spans a whole period.
    assign periodRestart = wrCyc && phaseSel_ff != '0;

    // The counter runs whatever software does; only a period end or a
    // restart brings it back to zero.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            zcCount_ff <= '0;
        end else if (periodRestart || periodEnd) begin
            zcCount_ff <= '0;
        end else begin
            zcCount_ff <= zcSum[CYC_W-1:0];
        end
    end

    // ----------------------------------------------------------------------
    // Running maxima
    // ----------------------------------------------------------------------

    logic [23:0] nxt_runMaxV, nxt_runMaxI;
    logic [POD_NPH-1:0] nxt_runPhV, nxt_runPhI;

    // Among the selected phases the largest new magnitude wins; on a
    // tie the lower phase keeps the mark.
    always_comb begin
        nxt_runMaxV = runMaxV_ff;
        nxt_runMaxI = runMaxI_ff;
        nxt_runPhV = runPhV_ff;
        nxt_runPhI = runPhI_ff;
        for (int p = 0; p < POD_NPH; p++) begin
            if (sampleValid && phaseSel_ff[p]) begin
                if (absV[p] > nxt_runMaxV) begin
                    nxt_runMaxV = absV[p];
                    nxt_runPhV = POD_NPH'(1) << p;
                end
                if (absI[p] > nxt_runMaxI) begin
                    nxt_runMaxI = absI[p];
                    nxt_runPhI = POD_NPH'(1) << p;
                end
            end
        end
    end

    // Samples of the closing cycle go to the closing period; the next
    // period then starts from zero.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            runMaxV_ff <= '0;
            runMaxI_ff <= '0;
            runPhV_ff <= '0;
            runPhI_ff <= '0;
        end else if (periodEnd || periodRestart) begin
            runMaxV_ff <= '0;
            runMaxI_ff <= '0;
            runPhV_ff <= '0;
            runPhI_ff <= '0;
        end else begin
            runMaxV_ff <= nxt_runMaxV;
            runMaxI_ff <= nxt_runMaxI;
            runPhV_ff <= nxt_runPhV;
            runPhI_ff <= nxt_runPhI;
        end
    end

    // The reported results move only at a period end and then hold for
    // the whole of the following period.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            peakV_ff <= '0;
            peakI_ff <= '0;
            peakPhV_ff <= '0;
            peakPhI_ff <= '0;
        end else if (periodEnd) begin
            peakV_ff <= nxt_runMaxV;
            peakI_ff <= nxt_runMaxI;
            peakPhV_ff <= nxt_runPhV;
            peakPhI_ff <= nxt_runPhI;
        end
    end

    // ----------------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------------

    // Software settings; level writes keep only the low 24 bits.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ovLevel_ff <= POD_LVL_RST;
            oiLevel_ff <= POD_LVL_RST;
            peakCycles_ff <= POD_CYC_RST[CYC_W-1:0];
            phaseSel_ff <= '0;
            irqMask_ff <= '0;
        end else begin
            if (wrOvl) begin
                ovLevel_ff <= regReq.wdata[23:0];
            end
            if (wrOil) begin
                oiLevel_ff <= regReq.wdata[23:0];
            end
            if (wrCyc) begin
                peakCycles_ff <= regReq.wdata[CYC_W-1:0];
            end
            if (wrMode) begin
                phaseSel_ff <= regReq.wdata[POD_SEL_LSB +: POD_NPH];
            end
            if (wrMsk) begin
                irqMask_ff <= {regReq.wdata[POD_ST_PKV],
                    regReq.wdata[POD_ST_PKI], regReq.wdata[POD_ST_OV],
                    regReq.wdata[POD_ST_OI]};
            end
        end
    end

    // ----------------------------------------------------------------------
    // Sticky flags
    // ----------------------------------------------------------------------

    logic clrOv, clrOi, clrPki, clrPkv;
    logic nxt_ovFlag, nxt_oiFlag, nxt_pkiFlag, nxt_pkvFlag;

    // A one clears, a zero leaves alone; an event in the clearing cycle
    // still sets the flag, so no event is ever lost.
    assign clrOv = wrSt1 && regReq.wdata[POD_ST_OV];
    assign clrOi = wrSt1 && regReq.wdata[POD_ST_OI];
    assign clrPki = wrSt1 && regReq.wdata[POD_ST_PKI];
    assign clrPkv = wrSt1 && regReq.wdata[POD_ST_PKV];
    assign nxt_ovFlag = (vOver != '0) || (ovFlag_ff && !clrOv);
    assign nxt_oiFlag = (iOver != '0) || (oiFlag_ff && !clrOi);
    assign nxt_pkiFlag = periodEnd || (pkiFlag_ff && !clrPki);
    assign nxt_pkvFlag = periodEnd || (pkvFlag_ff && !clrPkv);

    // Status flags and the phase bits that go with them.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ovFlag_ff <= 1'b0;
            oiFlag_ff <= 1'b0;
            pkiFlag_ff <= 1'b0;
            pkvFlag_ff <= 1'b0;
            overvoltage_phase_bits_ff <= '0;
            overcurrent_phase_bits_ff <= '0;
        end else begin
            ovFlag_ff <= nxt_ovFlag;
            oiFlag_ff <= nxt_oiFlag;
            pkiFlag_ff <= nxt_pkiFlag;
            pkvFlag_ff <= nxt_pkvFlag;
            overvoltage_phase_bits_ff <= vOver | (clrOv ? '0 : overvoltage_phase_bits_ff);
            overcurrent_phase_bits_ff <= iOver | (clrOi ? '0 : overcurrent_phase_bits_ff);
        end
    end

    // ----------------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------------

    // Built from the next flag values so the pin falls on the same edge
    // that sets the flag, and rises on the edge that clears the last one.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            interruptOut_n <= 1'b1;
        end else begin
            interruptOut_n <= ~|({nxt_pkvFlag, nxt_pkiFlag, nxt_ovFlag,
                nxt_oiFlag} & irqMask_ff);
        end
    end

    // ----------------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------------

    logic [31:0] rdMux;

    // Unused bits and unmapped addresses read as zero. Reads have no
    // side effect, so the host order of status then phase status is
    // safe to repeat.
    always_comb begin
        rdMux = 32'h00000000;
        if (regReq.addr == POD_ADDR_VPK) begin
            rdMux[23:0] = peakV_ff;
            rdMux[POD_PKPH_LSB +: POD_NPH] = peakPhV_ff;
        end else if (regReq.addr == POD_ADDR_IPK) begin
            rdMux[23:0] = peakI_ff;
            rdMux[POD_PKPH_LSB +: POD_NPH] = peakPhI_ff;
        end else if (regReq.addr == POD_ADDR_OVL) begin
            rdMux[23:0] = ovLevel_ff;
        end else if (regReq.addr == POD_ADDR_OIL) begin
            rdMux[23:0] = oiLevel_ff;
        end else if (regReq.addr == POD_ADDR_CYC) begin
            rdMux[CYC_W-1:0] = peakCycles_ff;
        end else if (regReq.addr == POD_ADDR_MODE) begin
            rdMux[POD_SEL_LSB +: POD_NPH] = phaseSel_ff;
        end else if (regReq.addr == POD_ADDR_ST1) begin
            rdMux[POD_ST_OI] = oiFlag_ff;
            rdMux[POD_ST_OV] = ovFlag_ff;
            rdMux[POD_ST_PKI] = pkiFlag_ff;
            rdMux[POD_ST_PKV] = pkvFlag_ff;
        end else if (regReq.addr == POD_ADDR_MSK1) begin
            rdMux[POD_ST_OI] = irqMask_ff[0];
            rdMux[POD_ST_OV] = irqMask_ff[1];
            rdMux[POD_ST_PKI] = irqMask_ff[2];
            rdMux[POD_ST_PKV] = irqMask_ff[3];
        end else if (regReq.addr == POD_ADDR_PHST) begin
            rdMux[POD_PH_OI_LSB +: POD_NPH] = overcurrent_phase_bits_ff;
            rdMux[POD_PH_OV_LSB +: POD_NPH] = overvoltage_phase_bits_ff;
        end
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 32'h00000000;
        end else if (regReq.rd) begin
            regRdData <= rdMux;
        end
    end

endmodule

//--- test/pod_detector_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port-level checks of the peak and overlevel detector
// ----------------------------------------------------------------
module pod_detector_properties
    import pod_pkg::*;
#(
    parameter int CYC_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pod_samples_t samples,
    input wire logic sampleValid,
    input wire logic [POD_NPH-1:0] zeroCross,
    input wire pod_regreq_t regReq,
    input wire logic [31:0] regRdData,
    input wire logic interruptOut_n
);
    logic [23:0] overvoltage_level_ff; // Shadow of the overvoltage level.
    logic [23:0] overcurrent_level_ff; // Shadow of the overcurrent level.
    logic [31:0] mask_ff; // Shadow of the defined mask bits.
    logic ovHit; // Some voltage sample lies above its level.
    logic oiHit; // Some current sample lies above its level.

    // Magnitude; the most negative code stays above every legal level.
    function automatic logic [23:0] mag(input logic [23:0] v);
        return v[23] ? 24'h000000 - v : v;
    endfunction

    // The shadows follow the write port, so no read-back is trusted.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            overvoltage_level_ff <= POD_LVL_RST;
            overcurrent_level_ff <= POD_LVL_RST;
        end else if (regReq.wr && regReq.addr == POD_ADDR_OVL) begin
            overvoltage_level_ff <= regReq.wdata[23:0];
        end else if (regReq.wr && regReq.addr == POD_ADDR_OIL) begin
            overcurrent_level_ff <= regReq.wdata[23:0];
        end
    end

    // Only the four flag positions are kept in the mask shadow.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mask_ff <= 32'h00000000;
        end else if (regReq.wr && regReq.addr == POD_ADDR_MSK1) begin
            mask_ff <= regReq.wdata & 32'h01860000;
        end
    end

    // A zero level flags even a zero sample.
    always_comb begin
        ovHit = 1'b0;
        oiHit = 1'b0;
        for (int i = 0; i < POD_NPH; i++) begin
            if (mag(samples.volt[i]) > overvoltage_level_ff || overvoltage_level_ff == '0) begin
                ovHit = sampleValid;
            end
            if (mag(samples.curr[i]) > overcurrent_level_ff || overcurrent_level_ff == '0) begin
                oiHit = sampleValid;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_reset_quiet: assert property (
        $rose(rst_b) |-> interruptOut_n && regRdData == 32'h0
    ) else $error("output not quiet after reset");
    a_irq_idle: assert property (
        mask_ff == '0 && $past(mask_ff) == '0 |-> interruptOut_n
    ) else $error("interrupt low with every flag masked");
    a_ov_irq: assert property (
        ovHit && mask_ff[POD_ST_OV] |=> !interruptOut_n
    ) else $error("overvoltage did not pull the interrupt");
    a_oi_irq: assert property (
        oiHit && mask_ff[POD_ST_OI] |=> !interruptOut_n
    ) else $error("overcurrent did not pull the interrupt");
    a_w1c_release: assert property (
        regReq.wr && regReq.addr == POD_ADDR_ST1 && regReq.wdata[18]
        && !ovHit && mask_ff == 32'h00040000 |=> interruptOut_n
    ) else $error("interrupt held after clearing its flag");
    a_level_pad: assert property (
        regReq.rd && (regReq.addr == POD_ADDR_OVL
        || regReq.addr == POD_ADDR_OIL) |=> regRdData[31:24] == 8'h00
    ) else $error("level read with nonzero upper byte");
    a_peak_onehot: assert property (
        regReq.rd && (regReq.addr == POD_ADDR_VPK
        || regReq.addr == POD_ADDR_IPK) |=> $onehot0(regRdData[26:24])
    ) else $error("peak phase mark not one-hot");
    a_unmapped_zero: assert property (
        regReq.rd && !regReq.wr && regReq.addr > 8'h20 |=> regRdData == '0
    ) else $error("unmapped read not zero");
    a_read_hold: assert property (
        !regReq.rd |=> $stable(regRdData)
    ) else $error("read data changed without a read");
endmodule

//--- test/pod_detector_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench of the peak and overlevel detector
// ----------------------------------------------------------------
module pod_detector_tb
    import pod_pkg::*;
;
    // One table row: optional write, then a read and its value.
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } pod_row_t;

    logic clk_sys;
    logic rst_b;
    pod_samples_t smp;
    logic sampleValid;
    logic [2:0] zeroCross;
    pod_regreq_t regReq;
    logic [31:0] regRdData;
    logic interruptOut_n;
    int miscompares;
    int checksDone;
    pod_row_t rows [16];

    pod_detector #(.CYC_W(8)) i_dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .samples(smp),
        .sampleValid(sampleValid),
        .zeroCross(zeroCross),
        .regReq(regReq),
        .regRdData(regRdData),
        .interruptOut_n(interruptOut_n)
    );

    // ----------------------------------------------------------------
    // Tasks; every strobe is lowered a full cycle before it may rise.
    // ----------------------------------------------------------------
    task automatic tick();
        @(negedge clk_sys);
    endtask
    task automatic chk(input string n, input logic [31:0] e,
            input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic irq(input logic e);
        chk("interrupt", {31'h0, e}, {31'h0, interruptOut_n});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regReq.wr = 1'b1;
        regReq.addr = a;
        regReq.wdata = d;
        tick();
        regReq.wr = 1'b0;
        tick();
    endtask
    task automatic rdc(input string n, input logic [7:0] a,
            input logic [31:0] e);
        regReq.rd = 1'b1;
        regReq.addr = a;
        tick();
        regReq.rd = 1'b0;
        tick();
        chk(n, e, regRdData);
    endtask
    task automatic pulse(); // One valid sample set.
        sampleValid = 1'b1;
        tick();
        sampleValid = 1'b0;
        tick();
    endtask
    task automatic zc(input logic [2:0] z);
        zeroCross = z;
        tick();
        zeroCross = 3'h0;
        tick();
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // A hang is cut short long after the sequence should be over.
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        smp = '0;
        sampleValid = 1'b0;
        zeroCross = 3'h0;
        regReq = '0;
        rows = '{'{1'b0, POD_ADDR_VPK, 32'h0, 32'h0},
            '{1'b0, POD_ADDR_IPK, 32'h0, 32'h0},
            '{1'b0, POD_ADDR_OVL, 32'h0, 32'h5a7540},
            '{1'b0, POD_ADDR_OIL, 32'h0, 32'h5a7540},
            '{1'b0, POD_ADDR_CYC, 32'h0, 32'h10},
            '{1'b0, POD_ADDR_MODE, 32'h0, 32'h0},
            '{1'b0, POD_ADDR_ST1, 32'h0, 32'h0},
            '{1'b0, POD_ADDR_MSK1, 32'h0, 32'h0},
            '{1'b0, POD_ADDR_PHST, 32'h0, 32'h0},
            '{1'b1, POD_ADDR_OVL, 32'hffffffff, 32'hffffff},
            '{1'b1, POD_ADDR_OIL, 32'h12345678, 32'h345678},
            '{1'b1, POD_ADDR_MODE, 32'hffffffff, 32'h1c},
            '{1'b1, POD_ADDR_MODE, 32'h0, 32'h0},
            '{1'b1, POD_ADDR_VPK, 32'hffffffff, 32'h0},
            '{1'b1, POD_ADDR_PHST, 32'hffffffff, 32'h0},
            '{1'b1, 8'h24, 32'hffffffff, 32'h0}};
        repeat (5) tick();
        chk("read data", 32'h0, regRdData);
        irq(1'b1);
        rst_b = 1'b1;
        tick();
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end
            rdc("register", rows[i].a, rows[i].e);
        end
        $display("test registers done");
        // Equal is not above; then phase B voltage, phase C current.
        wr(POD_ADDR_OVL, 32'h100);
        wr(POD_ADDR_OIL, 32'h100);
        wr(POD_ADDR_MSK1, 32'h40000);
        smp.volt[0] = 24'hffff00;
        smp.curr[0] = 24'h000100;
        pulse();
        rdc("status", POD_ADDR_ST1, 32'h0);
        smp = '0;
        smp.volt[1] = 24'hfffe00;
        pulse();
        irq(1'b0);
        rdc("status", POD_ADDR_ST1, 32'h40000);
        rdc("phase status", POD_ADDR_PHST, 32'h400);
        smp = '0;
        smp.curr[2] = 24'h000101;
        pulse();
        rdc("phase status", POD_ADDR_PHST, 32'h420);
        wr(POD_ADDR_ST1, 32'h40000);
        rdc("status", POD_ADDR_ST1, 32'h20000);
        rdc("phase status", POD_ADDR_PHST, 32'h20);
        irq(1'b1);
        wr(POD_ADDR_MSK1, 32'h20000);
        irq(1'b0);
        wr(POD_ADDR_ST1, 32'h20000);
        rdc("phase status", POD_ADDR_PHST, 32'h0);
        irq(1'b1);
        $display("test over-level done");
        // A zero level flags a zero sample; full scale flags nothing.
        wr(POD_ADDR_OIL, 32'h0);
        smp = '0;
        pulse();
        irq(1'b0);
        rdc("status", POD_ADDR_ST1, 32'h20000);
        wr(POD_ADDR_OIL, 32'h5a7540);
        wr(POD_ADDR_OVL, 32'h5a7540);
        wr(POD_ADDR_ST1, 32'h20000);
        wr(POD_ADDR_MSK1, 32'h60000);
        smp.volt = {3{24'h5a7540}};
        smp.curr[2] = 24'ha58ac0;
        pulse();
        irq(1'b1);
        rdc("status", POD_ADDR_ST1, 32'h0);
        $display("test level limits done");
        // Phases A and B selected, two crossings a period.
        wr(POD_ADDR_MODE, 32'h0c);
        wr(POD_ADDR_CYC, 32'h2);
        wr(POD_ADDR_MSK1, 32'h1800000);
        smp.curr = {24'h0, 24'hfffb00, 24'h000300};
        smp.volt = {24'h000900, 24'h0, 24'hfff900};
        sampleValid = 1'b1;
        zc(3'b001);
        rdc("voltage peak", POD_ADDR_VPK, 32'h0);
        zc(3'b010);
        sampleValid = 1'b0;
        rdc("current peak", POD_ADDR_IPK, 32'h2000500);
        rdc("voltage peak", POD_ADDR_VPK, 32'h1000700);
        rdc("status", POD_ADDR_ST1, 32'h1800000);
        irq(1'b0);
        wr(POD_ADDR_ST1, 32'h1800000);
        irq(1'b1);
        // A period-count write restarts the count and the maxima.
        smp.curr = {24'h0, 24'h0, 24'h000200};
        smp.volt = {24'h000900, 24'h000100, 24'h0};
        sampleValid = 1'b1;
        zc(3'b001);
        wr(POD_ADDR_CYC, 32'h2);
        zc(3'b001);
        rdc("status", POD_ADDR_ST1, 32'h0);
        rdc("current peak", POD_ADDR_IPK, 32'h2000500);
        zc(3'b011);
        rdc("current peak", POD_ADDR_IPK, 32'h1000200);
        rdc("voltage peak", POD_ADDR_VPK, 32'h2000100);
        $display("test peak periods done");
        // A reset in mid-run drops the raised flags and the results.
        sampleValid = 1'b0;
        rst_b = 1'b0;
        tick();
        irq(1'b1);
        rst_b = 1'b1;
        tick();
        rdc("voltage peak", POD_ADDR_VPK, 32'h0);
        rdc("status", POD_ADDR_ST1, 32'h0);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule

bind pod_detector pod_detector_properties #(.CYC_W(CYC_W)) i_chk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .samples(samples),
    .sampleValid(sampleValid),
    .zeroCross(zeroCross),
    .regReq(regReq),
    .regRdData(regRdData),
    .interruptOut_n(interruptOut_n)
);
